// >>> design/lsbm_event_monitor.sv
// Load/store blocking event detection and counting for the core memory pipeline
`include "lsbm_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module lsbm_event_monitor (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic [`LSBM_CODE_W-1:0]   sel_event,
  input  wire logic [`LSBM_CODE_W-1:0]   sel_umask,
  input  wire logic                      load_valid,
  input  wire logic [`LSBM_ADDR_W-1:0]   load_addr,
  input  wire logic [`LSBM_SIZE_W-1:0]   load_bytes,
  input  wire logic                      load_uncacheable,
  input  wire logic                      load_io,
  input  wire logic                      load_retire_other,
  input  wire logic                      store_pending,
  input  wire logic [`LSBM_ADDR_W-1:0]   store_addr,
  input  wire logic [`LSBM_SIZE_W-1:0]   store_bytes,
  input  wire logic                      store_commit,
  input  wire logic [`LSBM_MISS_W-1:0]   miss_outstanding,
  input  wire logic                      miss_new,
  input  wire logic                      lock_in_progress,
  input  wire logic                      drain_serialize,
  input  wire logic                      drain_synchronize,
  input  wire logic                      drain_int_ack,
  input  wire logic                      drain_cache_flush,
  input  wire logic                      order_wait_start,
  input  wire logic                      order_observed,
  input  wire logic                      order_bus_read,
  input  wire logic                      snoop_response,
  input  wire logic                      snoop_port_busy,
  input  wire logic                      store_request,
  output logic      [`LSBM_CNT_W-1:0]    event_count_reg,
  output logic                           event_hit_reg,
  output logic                           load_hold_reg,
  output logic                           store_order_stall_reg,
  output logic                           store_replay_reg
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Byte ranges of the load and the blocking store
  logic [`LSBM_ADDR_W:0] ld_end;
  logic [`LSBM_ADDR_W:0] st_end;
  logic [`LSBM_SIZE_W:0] ld_qw_end;
  logic [6:0]            ld_line_end;
  logic [3:0]            st_align_mask;
  logic                  range_touch;
  logic                  contained;
  logic                  partial_cover;
  logic                  misalign_offset;
  logic                  split_qword;
  logic                  alias_4k;
  logic                  split_line;
  logic                  overlap_hit;
  logic                  load_wait_retire_event;
  logic                  load_dcache_stall_event;
  logic                  drain_any;
  logic                  snoop_stall;
  logic                  sel_overlap;
  logic                  sel_retire;
  logic                  sel_dcache;
  logic                  sel_drain;
  logic                  sel_order;
  logic                  sel_snoop;
  logic                  count_hit;
  lsbm_pkg::lsbm_hold_t  hold_state_reg;

  assign ld_end        = {1'b0, load_addr} + {{(`LSBM_ADDR_W-`LSBM_SIZE_W+1){1'b0}}, load_bytes};
  assign st_end        = {1'b0, store_addr} + {{(`LSBM_ADDR_W-`LSBM_SIZE_W+1){1'b0}}, store_bytes};
  assign range_touch   = ({1'b0, load_addr} < st_end) && ({1'b0, store_addr} < ld_end);
  assign contained     = (load_addr >= store_addr) && (ld_end <= st_end);
  assign partial_cover = range_touch && !contained;
  assign st_align_mask = store_bytes[3:0] - 4'h1;
  assign misalign_offset = contained && ((store_addr[3:0] & st_align_mask) != 4'h0)
                           && (load_addr != store_addr);
  assign ld_qw_end     = {3'b000, load_addr[2:0]} + {1'b0, load_bytes};
  assign split_qword   = (ld_qw_end > {1'b0, `LSBM_QWORD_BYTES})
                         && (load_bytes != `LSBM_NOSPLIT_SIZE);
  assign alias_4k      = (load_addr[`LSBM_PAGE_LSB-1:0] == store_addr[`LSBM_PAGE_LSB-1:0])
                         && (load_addr[`LSBM_ADDR_W-1:`LSBM_PAGE_LSB]
                             != store_addr[`LSBM_ADDR_W-1:`LSBM_PAGE_LSB]);
  assign overlap_hit   = load_valid && store_pending
                         && (partial_cover || misalign_offset || split_qword || alias_4k);

  assign ld_line_end   = {1'b0, load_addr[5:0]} + {2'b00, load_bytes};
  assign split_line    = ld_line_end > `LSBM_LINE_BYTES;
  assign load_wait_retire_event = load_valid
                                  && (load_uncacheable || split_line || load_retire_other);
  assign load_dcache_stall_event = load_valid
                                   && ((miss_new && miss_outstanding >= `LSBM_MISS_MAX)
                                       || split_line || load_uncacheable || load_io
                                       || lock_in_progress);

  assign drain_any     = drain_serialize || drain_synchronize
                         || drain_int_ack || drain_cache_flush;
  assign snoop_stall   = snoop_port_busy && store_request;

  assign sel_overlap   = (sel_event == `LSBM_EV_LOAD)  && (sel_umask == `LSBM_UM_OVERLAP);
  assign sel_retire    = (sel_event == `LSBM_EV_LOAD)  && (sel_umask == `LSBM_UM_RETIRE);
  assign sel_dcache    = (sel_event == `LSBM_EV_LOAD)  && (sel_umask == `LSBM_UM_DCACHE);
  assign sel_drain     = (sel_event == `LSBM_EV_STORE) && (sel_umask == `LSBM_UM_DRAIN);
  assign sel_order     = (sel_event == `LSBM_EV_STORE) && (sel_umask == `LSBM_UM_ORDER);
  assign sel_snoop     = (sel_event == `LSBM_EV_STORE) && (sel_umask == `LSBM_UM_SNOOP);

  // Only the one matching event source reaches the counter
  assign count_hit = (sel_overlap && overlap_hit)
                     || (sel_retire && load_wait_retire_event)
                     || (sel_dcache && load_dcache_stall_event)
                     || (sel_drain  && drain_any)
                     || (sel_order  && store_order_stall_reg)
                     || (sel_snoop  && snoop_stall);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      event_count_reg <= `LSBM_CNT_RST;
      event_hit_reg   <= 1'b0;
    end else begin
      event_hit_reg <= count_hit;
      if (count_hit) begin
        event_count_reg <= event_count_reg + `LSBM_CNT_ONE;
      end
    end
  end

  // Load hold: a new block wins over a commit in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hold_state_reg <= lsbm_pkg::LSBM_HOLD_IDLE;
      load_hold_reg  <= 1'b0;
    end else begin
      unique case (hold_state_reg)
        lsbm_pkg::LSBM_HOLD_IDLE: begin
          if (overlap_hit) begin
            hold_state_reg <= lsbm_pkg::LSBM_HOLD_WAIT;
            load_hold_reg  <= 1'b1;
          end
        end
        lsbm_pkg::LSBM_HOLD_WAIT: begin
          if (store_commit && !overlap_hit) begin
            hold_state_reg <= lsbm_pkg::LSBM_HOLD_IDLE;
            load_hold_reg  <= 1'b0;
          end
        end
      endcase
    end
  end

  // Ordering stall: start wins over end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      store_order_stall_reg <= 1'b0;
    end else if (order_wait_start) begin
      store_order_stall_reg <= 1'b1;
    end else if (order_bus_read ? snoop_response : order_observed) begin
      store_order_stall_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      store_replay_reg <= 1'b0;
    end else begin
      store_replay_reg <= snoop_stall;
    end
  end

  sequence drain_run3;
    (sel_drain && drain_any)[*3];
  endsequence

  sequence overlap_block;
    sel_overlap && overlap_hit;
  endsequence

  AST_OVERLAP_COUNT: assert property (
    overlap_block |=> event_count_reg == $past(event_count_reg) + `LSBM_CNT_ONE)
    else $error("Overlap block not counted");

  AST_NO_SPLIT16: assert property (
    load_valid && store_pending && load_bytes == `LSBM_NOSPLIT_SIZE
    && !partial_cover && !misalign_offset && !alias_4k |-> !overlap_hit)
    else $error("16-byte load flagged as qword split");

  AST_ALIAS_4K: assert property (
    load_valid && store_pending && alias_4k |-> overlap_hit)
    else $error("4K alias not flagged");

  AST_HOLD_UNTIL_COMMIT: assert property (
    overlap_hit ##1 !store_commit[*2] |-> load_hold_reg && $past(load_hold_reg))
    else $error("Load released before store commit");

  AST_RETIRE_COUNT: assert property (
    sel_retire && load_valid && load_uncacheable |=> event_hit_reg)
    else $error("Uncacheable load not counted");

  AST_DCACHE_LOCK: assert property (
    sel_dcache && load_valid && lock_in_progress
    |=> event_count_reg == $past(event_count_reg) + `LSBM_CNT_ONE)
    else $error("Locked load block not counted");

  AST_DRAIN_CYCLES: assert property (
    drain_run3 |=> event_count_reg == $past(event_count_reg, 3) + 32'h0000_0003)
    else $error("Drain cycles miscounted");

  AST_ORDER_COUNT: assert property (
    sel_order && store_order_stall_reg |=> event_hit_reg)
    else $error("Ordering stall cycle not counted");

  AST_ORDER_SNOOP_END: assert property (
    store_order_stall_reg && order_bus_read && snoop_response && !order_wait_start
    |=> !store_order_stall_reg)
    else $error("Ordering stall did not end at snoop response");

  AST_SNOOP_COUNT: assert property (
    sel_snoop && snoop_port_busy && store_request |=> event_hit_reg)
    else $error("Snoop stall not counted");

  AST_SNOOP_REPLAY: assert property (
    snoop_stall |=> store_replay_reg ##1 (store_replay_reg == $past(snoop_stall)))
    else $error("Snoop-stalled store not resubmitted");

  AST_HOLD_WHEN_UNSELECTED: assert property (
    !(sel_overlap || sel_retire || sel_dcache || sel_drain || sel_order || sel_snoop)
    |=> event_count_reg == $past(event_count_reg) && !event_hit_reg)
    else $error("Counter moved with no event selected");

endmodule : lsbm_event_monitor

`default_nettype wire

// >>> design/lsbm_consts.svh
// Constants for the load/store blocking event monitor
`ifndef LSBM_CONSTS_SVH
`define LSBM_CONSTS_SVH

`define LSBM_CNT_W        32
`define LSBM_ADDR_W       32
`define LSBM_CODE_W       8
`define LSBM_SIZE_W       5
`define LSBM_MISS_W       4

`define LSBM_EV_LOAD      8'h03
`define LSBM_EV_STORE     8'h04
`define LSBM_UM_OVERLAP   8'h08
`define LSBM_UM_RETIRE    8'h10
`define LSBM_UM_DCACHE    8'h20
`define LSBM_UM_DRAIN     8'h01
`define LSBM_UM_ORDER     8'h02
`define LSBM_UM_SNOOP     8'h08

`define LSBM_CNT_RST      32'h0000_0000
`define LSBM_CNT_ONE      32'h0000_0001
`define LSBM_QWORD_BYTES  5'h08
`define LSBM_NOSPLIT_SIZE 5'h10
`define LSBM_LINE_BYTES   7'h40
`define LSBM_PAGE_LSB     12
`define LSBM_MISS_MAX     4'h8

`endif

// >>> design/lsbm_pkg.sv
// Types for the load/store blocking event monitor
package lsbm_pkg;

  typedef enum logic {
    LSBM_HOLD_IDLE,
    LSBM_HOLD_WAIT
  } lsbm_hold_t;

endpackage : lsbm_pkg

// >>> test/lsbm_pipe_model.sv
// Random event source model of the core load/store pipeline and data cache
`timescale 1ns/1ps
`default_nettype none

module lsbm_pipe_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  output var  logic        load_valid        = 1'b0,
  output var  logic [31:0] load_addr         = 32'h0000_0000,
  output var  logic [4:0]  load_bytes        = 5'h01,
  output var  logic        load_uncacheable  = 1'b0,
  output var  logic        load_io           = 1'b0,
  output var  logic        load_retire_other = 1'b0,
  output var  logic        store_pending     = 1'b0,
  output var  logic [31:0] store_addr        = 32'h0000_0000,
  output var  logic [4:0]  store_bytes       = 5'h01,
  output var  logic        store_commit      = 1'b0,
  output var  logic [3:0]  miss_outstanding  = 4'h0,
  output var  logic        miss_new          = 1'b0,
  output var  logic        lock_in_progress  = 1'b0,
  output var  logic        drain_serialize   = 1'b0,
  output var  logic        drain_synchronize = 1'b0,
  output var  logic        drain_int_ack     = 1'b0,
  output var  logic        drain_cache_flush = 1'b0,
  output var  logic        order_wait_start  = 1'b0,
  output var  logic        order_observed    = 1'b0,
  output var  logic        order_bus_read    = 1'b0,
  output var  logic        snoop_response    = 1'b0,
  output var  logic        snoop_port_busy   = 1'b0,
  output var  logic        store_request     = 1'b0
);
  integer      seed = 32'h1626;
  logic [31:0] r;
  logic [31:0] q;

  // Narrow address space so overlaps, aliases and line splits happen often
  always @(posedge clk) begin
    r = $random(seed);
    q = $random(seed);
    if (!nrst) begin
      r = 32'h0000_0000;
      q = 32'h0000_0000;
    end
    load_valid <= r[0];
    load_addr <= {19'h0_0000, r[1], 6'h00, r[7:2]};
    load_bytes <= 5'h01 << (r[10:8] % 3'h5);
    store_addr <= {19'h0_0000, r[11], 6'h00, r[17:12]};
    store_bytes <= 5'h01 << (r[20:18] % 3'h5);
    store_pending <= r[21];
    store_commit <= r[22] & r[23];
    load_uncacheable <= r[24] & r[25];
    load_io <= r[26] & r[27];
    load_retire_other <= r[28] & r[29];
    miss_new <= r[30];
    lock_in_progress <= r[31] & q[0];
    miss_outstanding <= q[4:1];
    drain_serialize <= q[5] & q[6];
    drain_synchronize <= q[7] & q[8];
    drain_int_ack <= q[9] & q[10];
    drain_cache_flush <= q[11] & q[12];
    order_wait_start <= q[13] & q[14] & q[15];
    order_observed <= q[16] & q[17];
    order_bus_read <= q[18];
    snoop_response <= q[19] & q[20];
    snoop_port_busy <= q[21];
    store_request <= q[22];
  end
endmodule : lsbm_pipe_model

`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the load/store blocking event monitor
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  sel_event = 8'h00;
  logic [7:0]  sel_umask = 8'h00;
  logic        load_valid, load_uncacheable, load_io, load_retire_other, store_pending;
  logic        store_commit, miss_new, lock_in_progress, drain_serialize, drain_synchronize;
  logic        drain_int_ack, drain_cache_flush, order_wait_start, order_observed;
  logic        order_bus_read, snoop_response, snoop_port_busy, store_request;
  logic [31:0] load_addr, store_addr, event_count_reg, exp_cnt;
  logic [4:0]  load_bytes, store_bytes;
  logic [3:0]  miss_outstanding;
  logic        event_hit_reg, load_hold_reg, store_order_stall_reg, store_replay_reg;
  logic        exp_hit, exp_hold, exp_stall, exp_rep;
  integer      err_count = 0;
  integer      tests_run = 0;
  integer      i;
  // Selections, refused pairs last
  logic [15:0] tab [0:7] = '{16'h0308, 16'h0310, 16'h0320, 16'h0401,
                             16'h0402, 16'h0408, 16'h0301, 16'h0420};

  always #5 clk = ~clk;

  lsbm_event_monitor i_dut (.*);
  lsbm_pipe_model    i_src (.*);

  function automatic logic overlap_f();
    logic [32:0] ls, le, ss, se;
    logic        cont;
    ls = {1'b0, load_addr};
    le = ls + load_bytes;
    ss = {1'b0, store_addr};
    se = ss + store_bytes;
    cont = ls >= ss && le <= se;
    return load_valid & store_pending & ((ls < se && ss < le && !cont)
      | (cont && ls != ss && (store_addr[3:0] & (store_bytes[3:0] - 4'h1)) != 4'h0)
      | (({2'b00, load_addr[2:0]} + load_bytes) > 5'h08 && load_bytes != 5'h10)
      | (load_addr[11:0] == store_addr[11:0] && load_addr[31:12] != store_addr[31:12]));
  endfunction : overlap_f

  function automatic logic split_f();
    return ({1'b0, load_addr[5:0]} + load_bytes) > 7'h40;
  endfunction : split_f

  function automatic logic hit_f();
    case ({sel_event, sel_umask})
      16'h0308: return overlap_f();
      16'h0310: return load_valid & (load_uncacheable | split_f() | load_retire_other);
      16'h0320: return load_valid & ((miss_new & miss_outstanding >= 4'h8) | split_f()
                       | load_uncacheable | load_io | lock_in_progress);
      16'h0401: return drain_serialize | drain_synchronize | drain_int_ack | drain_cache_flush;
      16'h0402: return exp_stall;
      16'h0408: return snoop_port_busy & store_request;
      default:  return 1'b0;
    endcase
  endfunction : hit_f

  always @(posedge clk) begin
    if (!nrst) begin
      {exp_hit, exp_hold, exp_stall, exp_rep} = 4'h0;
      exp_cnt = 32'h0000_0000;
    end else begin
      exp_hit = hit_f();
      exp_cnt = exp_cnt + exp_hit;
      exp_rep = snoop_port_busy & store_request;
      exp_hold = overlap_f() | (exp_hold & ~store_commit);
      exp_stall = order_wait_start
        | (exp_stall & ~(order_bus_read ? snoop_response : order_observed));
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  always @(negedge clk) begin
    chk(event_count_reg, exp_cnt);
    chk({31'h0, event_hit_reg}, {31'h0, exp_hit});
    chk({31'h0, load_hold_reg}, {31'h0, exp_hold});
    chk({31'h0, store_order_stall_reg}, {31'h0, exp_stall});
    chk({31'h0, store_replay_reg}, {31'h0, exp_rep});
  end

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk) {sel_event, sel_umask} <= tab[i];
      repeat (300) @(posedge clk);
      // Mid-run reset must clear the count and every flag
      if (i == 3) begin
        nrst <= 1'b0;
        @(posedge clk) nrst <= 1'b1;
      end
    end
    results();
  end

  initial begin
    #40000;
    err_count++;
    results();
  end
endmodule : tb

`default_nettype wire
